// [csia_core.sv]
module csia_core (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic                 push,
	input  wire logic                 pop,
	input  wire logic [15:0]          push_pc,
	output logic      [15:0]          pop_pc,
	output logic                      stack_room_flag,
	input  wire logic [7:0]           bank_select,
	input  wire csia_pkg::csia_acc_t  acc,
	output csia_pkg::csia_mem_t       mem,
	input  wire logic [7:0]           mem_rdata,
	output logic      [7:0]           ind_rdata,
	output logic                      result_null_set
);

	// ====================================================================
	// State
	csia_pkg::csia_state_t state_ff;
	csia_pkg::csia_state_t nxt_state;

	logic [7:0] cur_ptr;
	logic       ptr_null;
	logic       bus_wr;
	logic [3:0] sp_dn;

	// Post-access step; wraps naturally at eight bits
	function automatic logic [7:0] step_ptr(input logic [7:0] p, input logic [1:0] m);
		logic [7:0] r;
		r = p;
		if (m == csia_pkg::STEP_DEC) begin
			r = p - 8'h01;
		end else if (m == csia_pkg::STEP_INC) begin
			r = p + 8'h01;
		end
		return r;
	endfunction

	// ====================================================================
	// Indirect path, resolved in the same cycle as the request
	assign cur_ptr  = acc.sel ? state_ff.p1 : state_ff.p0;
	assign ptr_null = (cur_ptr == 8'h00)
		|| (cur_ptr == csia_pkg::IND_PORT0_ADDR)
		|| (cur_ptr == csia_pkg::IND_PORT1_ADDR);
	assign sp_dn    = state_ff.sp - 4'h1;

	// Memory strobes are gated so null targets never touch the file
	always_comb begin
		mem.rd    = acc.vld && !acc.wr && !ptr_null;
		mem.wr    = acc.vld && acc.wr && !ptr_null;
		mem.bank  = bank_select;
		mem.addr  = cur_ptr;
		mem.wdata = acc.wdata;
	end

	assign bus_wr = state_ff.dph && state_ff.dwr;

	// ====================================================================
	// Next state
	always_comb begin
		nxt_state = state_ff;
		nxt_state.nul = 1'b0;

		// Stack; simultaneous push and pop cancel out
		if (push && !pop) begin
			nxt_state.stk[state_ff.sp] = push_pc;
			nxt_state.sp = state_ff.sp + 4'h1;
			if (state_ff.sp == csia_pkg::SP_TOP) begin
				nxt_state.lock = 1'b1;
			end
		end else if (pop && !push) begin
			nxt_state.sp = sp_dn;
		end

		// Indirect access: result lands in flops one cycle on
		if (acc.vld) begin
			if (!acc.wr) begin
				nxt_state.rdat = ptr_null ? 8'h00 : mem_rdata;
				nxt_state.nul  = ptr_null;
			end
			if (acc.sel) begin
				nxt_state.p1 = step_ptr(state_ff.p1,
					state_ff.mode[3:2]);
			end else begin
				nxt_state.p0 = step_ptr(state_ff.p0,
					state_ff.mode[1:0]);
			end
		end

		// Software write wins over a same-cycle step of that pointer
		if (bus_wr) begin
			case (state_ff.daddr)
				csia_pkg::OFS_PTR0: begin
					nxt_state.p0 = hwdata[7:0];
				end
				csia_pkg::OFS_PTR1: begin
					nxt_state.p1 = hwdata[7:0];
				end
				csia_pkg::OFS_ARITH: begin
					nxt_state.mode = hwdata[7:4];
				end
				default: begin
					nxt_state.lock = nxt_state.lock;
				end
			endcase
		end

		// Address phase capture; only word slots matter
		nxt_state.dph = hsel && hready && (htrans == csia_pkg::HTRANS_NONSEQ);
		if (hsel && hready) begin
			nxt_state.dwr   = hwrite;
			nxt_state.daddr = haddr[7:0];
		end
	end

	// ====================================================================
	// Registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff       <= '0;
			state_ff.sp    <= csia_pkg::SP_RST;
			state_ff.lock  <= 1'b0;
			state_ff.p0    <= csia_pkg::PTR_RST;
			state_ff.p1    <= csia_pkg::PTR_RST;
			state_ff.mode  <= csia_pkg::MODE_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ====================================================================
	// Outputs
	// Only pc enters the stack; the high latch is not even visible here
	assign pop_pc          = state_ff.stk[sp_dn];
	assign stack_room_flag = !state_ff.lock
		&& (state_ff.sp != csia_pkg::SP_TOP);
	assign ind_rdata       = state_ff.rdat;
	assign result_null_set = state_ff.nul;
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;

	// Read mux looks at live flops so a write just before is seen
	always_comb begin
		hrdata = 32'h0000_0000;
		if (state_ff.dph && !state_ff.dwr) begin
			case (state_ff.daddr)
				csia_pkg::OFS_PTR0: begin
					hrdata[7:0] = state_ff.p0;
				end
				csia_pkg::OFS_PTR1: begin
					hrdata[7:0] = state_ff.p1;
				end
				csia_pkg::OFS_ARITH: begin
					hrdata[7:4] = state_ff.mode;
				end
				csia_pkg::OFS_CPUST: begin
					hrdata[csia_pkg::ROOM_BIT] = stack_room_flag;
				end
				default: begin
					hrdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ====================================================================
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Stack steps that the properties below are built from
	sequence s_push_only;
		push && !pop && !acc.vld;
	endsequence

	sequence s_pop_only;
		pop && !push;
	endsequence

	sequence s_wrap_push;
		push && !pop && (state_ff.sp == csia_pkg::SP_TOP);
	endsequence

	sequence s_idle;
		!push && !pop;
	endsequence

	a_room_at_top: assert property (
		(state_ff.sp == csia_pkg::SP_TOP) |-> !stack_room_flag)
		else $error("room flag set at top of stack");

	a_wrap_lock_hold: assert property (
		s_wrap_push |=> !stack_room_flag [*8])
		else $error("room flag returned after wrap");

	a_push_advance: assert property (
		push && !pop |=> state_ff.sp == $past(state_ff.sp) + 4'h1)
		else $error("push did not advance stack pointer");

	a_push_pop_data: assert property (
		s_push_only ##1 s_pop_only |-> pop_pc == $past(push_pc))
		else $error("pop returned wrong return address");

	a_pop_first_room: assert property (
		((state_ff.sp == csia_pkg::SP_RST) and s_pop_only) |=> !stack_room_flag)
		else $error("pop from empty stack left room flag set");

	a_null_read: assert property (
		acc.vld && !acc.wr && ptr_null |=> ind_rdata == 8'h00 && result_null_set)
		else $error("null indirect read gave data or no null flag");

	a_null_write: assert property (
		acc.vld && acc.wr && ptr_null |-> !mem.wr && !mem.rd)
		else $error("null indirect write reached memory");

	a_step_incr: assert property (
		acc.vld && !acc.sel && (state_ff.mode[1:0] == csia_pkg::STEP_INC)
		&& !bus_wr |=> state_ff.p0 == $past(state_ff.p0) + 8'h01)
		else $error("pointer 0 did not increment");

	a_step_decr: assert property (
		acc.vld && acc.sel && (state_ff.mode[3:2] == csia_pkg::STEP_DEC)
		&& !bus_wr |=> state_ff.p1 == $past(state_ff.p1) - 8'h01)
		else $error("pointer 1 did not decrement");

	a_step_hold: assert property (
		acc.vld && !acc.sel && state_ff.mode[1] && !bus_wr
		|=> $stable(state_ff.p0))
		else $error("pointer 0 moved in hold mode");

	a_step_no_null: assert property (
		acc.vld && acc.wr |=> !result_null_set)
		else $error("null flag raised by write or step");

	a_room_readonly: assert property (
		bus_wr && (state_ff.daddr == csia_pkg::OFS_CPUST) && !push && !pop
		|=> $stable(stack_room_flag))
		else $error("software write changed room flag");

	// ====================================================================
	// Stack pop data, pointer movement and the room flag
	a_gap_pop_data: assert property (
		s_push_only ##1 s_idle ##1 s_pop_only |-> pop_pc == $past(push_pc, 2))
		else $error("pop after a gap returned wrong return address");

	a_pop_retreat: assert property (
		s_pop_only |=> state_ff.sp == $past(state_ff.sp) - 4'h1)
		else $error("pop did not lower stack pointer");

	a_lock_sticky: assert property (
		state_ff.lock |=> state_ff.lock && !stack_room_flag)
		else $error("room flag lock released before reset");

	a_room_below_top: assert property (
		!state_ff.lock && (state_ff.sp != csia_pkg::SP_TOP) |-> stack_room_flag)
		else $error("room flag clear below top without lock");

	a_room_idle_stable: assert property (
		s_idle |=> $stable(stack_room_flag))
		else $error("room flag moved without push or pop");

	// ====================================================================
	// Indirect data path and pointer stepping
	a_read_data: assert property (
		acc.vld && !acc.wr && !ptr_null |=> ind_rdata == $past(mem_rdata))
		else $error("indirect read did not return memory data");

	a_mem_target: assert property (
		acc.vld && !ptr_null |-> mem.bank == bank_select && mem.addr == cur_ptr)
		else $error("indirect access went to wrong bank or address");

	a_read_one_cycle: assert property (
		acc.vld && !acc.wr && !ptr_null |-> mem.rd && !mem.wr)
		else $error("indirect read not issued in its own cycle");

	a_null_only_read: assert property (
		!(acc.vld && !acc.wr && ptr_null) |=> !result_null_set)
		else $error("null flag raised without a null read");

	a_write_keeps_data: assert property (
		acc.vld && acc.wr |=> $stable(ind_rdata))
		else $error("indirect write changed read result");

	a_step_p1_incr: assert property (
		acc.vld && acc.sel && (state_ff.mode[3:2] == csia_pkg::STEP_INC)
		&& !bus_wr |=> state_ff.p1 == $past(state_ff.p1) + 8'h01)
		else $error("pointer 1 did not increment");

	a_step_p0_decr: assert property (
		acc.vld && !acc.sel && (state_ff.mode[1:0] == csia_pkg::STEP_DEC)
		&& !bus_wr |=> state_ff.p0 == $past(state_ff.p0) - 8'h01)
		else $error("pointer 0 did not decrement");

	a_step_p1_hold: assert property (
		acc.vld && acc.sel && state_ff.mode[3] && !bus_wr
		|=> $stable(state_ff.p1))
		else $error("pointer 1 moved in hold mode");

	// ====================================================================
	// Software access to pointers and modes
	a_ptr_write: assert property (
		bus_wr && (state_ff.daddr == csia_pkg::OFS_PTR0)
		|=> state_ff.p0 == $past(hwdata[7:0]))
		else $error("pointer 0 write did not land");

	a_mode_write: assert property (
		bus_wr && (state_ff.daddr == csia_pkg::OFS_ARITH)
		|=> state_ff.mode == $past(hwdata[7:4]))
		else $error("mode write did not land");

endmodule

// [csia_mem_model.sv]
// ====================================================================
// Data memory behind the indirect ports
module csia_mem_model (
	input  wire logic                hclk,
	input  wire csia_pkg::csia_mem_t mem,
	output logic [7:0]               mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] last_ff = 8'h5a;

	// Contents depend on bank and address, so a wrong bank reads wrong data
	function automatic logic [7:0] pat(input logic [7:0] b, input logic [7:0] a);
		return a ^ {b[3:0], b[7:4]} ^ 8'ha5;
	endfunction

	// Outside a read the bus shows the inverse of the last byte, never a stale copy
	assign mem_rdata = mem.rd ? pat(mem.bank, mem.addr) : ~last_ff;

	// Remember the last byte handed out
	always_ff @(posedge hclk) begin
		if (mem.rd) begin
			last_ff <= mem_rdata;
		end
	end
endmodule

// [csia_pkg.sv]
package csia_pkg;

	// ====================================================================
	// Register map, word aligned, byte addresses
	localparam logic [7:0] OFS_PTR0   = 8'h00;
	localparam logic [7:0] OFS_PTR1   = 8'h04;
	localparam logic [7:0] OFS_ARITH  = 8'h08;
	localparam logic [7:0] OFS_CPUST  = 8'h0C;

	// ====================================================================
	// Field positions
	localparam int PTR1_MODE_LSB = 6;
	localparam int PTR0_MODE_LSB = 4;
	localparam int ROOM_BIT      = 0;

	// ====================================================================
	// Reset values and sizes
	localparam logic [3:0] SP_RST    = 4'h0;
	localparam logic [3:0] SP_TOP    = 4'hF;
	localparam logic [3:0] MODE_RST  = 4'h0;
	localparam logic [7:0] PTR_RST   = 8'h00;
	localparam int         STK_DEPTH = 16;

	// ====================================================================
	// Data addresses of the two indirect ports (arbitrary defaults)
	localparam logic [7:0] IND_PORT0_ADDR = 8'h00;
	localparam logic [7:0] IND_PORT1_ADDR = 8'h08;

	// ====================================================================
	// Step mode encoding
	localparam logic [1:0] STEP_DEC = 2'b00;
	localparam logic [1:0] STEP_INC = 2'b01;

	// ====================================================================
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	// Indirect access request from the execution path
	typedef struct packed {
		logic       vld;
		logic       sel;
		logic       wr;
		logic [7:0] wdata;
	} csia_acc_t;

	// Data memory request towards the file
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csia_mem_t;

	// Whole state of the block
	typedef struct packed {
		logic [15:0][15:0] stk;
		logic [3:0]        sp;
		logic              lock;
		logic [7:0]        p0;
		logic [7:0]        p1;
		logic [3:0]        mode;
		logic [7:0]        rdat;
		logic              nul;
		logic              dph;
		logic              dwr;
		logic [7:0]        daddr;
	} csia_state_t;

endpackage

// [tb_core_stack_and_indirect_addressing.sv]
module tb_core_stack_and_indirect_addressing;
	timeunit 1ns;
	timeprecision 100ps;

	logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic                push, pop, stack_room_flag, result_null_set;
	logic [31:0]         haddr, hwdata, hrdata, r;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [15:0]         push_pc, pop_pc;
	logic [15:0]         es [16];
	logic [7:0]          bank_select, mem_rdata, ind_rdata, p, x;
	csia_pkg::csia_acc_t acc;
	csia_pkg::csia_mem_t mem;
	int                  n_mismatch, num_checks, cyc, sp;
	logic [31:0]         seed = 32'h0000_6e67;

	assign hready = hreadyout;

	csia_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .push(push), .pop(pop),
		.push_pc(push_pc), .pop_pc(pop_pc), .stack_room_flag(stack_room_flag),
		.bank_select(bank_select), .acc(acc), .mem(mem), .mem_rdata(mem_rdata),
		.ind_rdata(ind_rdata), .result_null_set(result_null_set));
	csia_mem_model u_mem (.hclk(hclk), .mem(mem), .mem_rdata(mem_rdata));

	// ====================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One single AHB transfer; waits on hready, no assumed latency
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h00_0000, a};
		htrans <= csia_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		sp = 0;
	endtask

	// One push or pop pulse; pop data is looked at in the pop cycle
	task automatic stk(input logic ps, input logic pp, input logic [15:0] pc);
		@(posedge hclk);
		push <= ps;
		pop <= pp;
		push_pc <= pc;
		#1;
		if (pp) chk(pop_pc, es[(sp - 1) & 15]);
		@(posedge hclk);
		push <= 1'b0;
		pop <= 1'b0;
		if (ps) es[sp] = pc;
		sp = ps ? (sp + 1) & 15 : (sp - 1) & 15;
	endtask

	// One indirect access with pointer a, mode md, on the chosen pointer
	task automatic ind(input logic s, input logic w, input logic [7:0] a, input logic [1:0] md);
		logic n;
		n = (a == 8'h00) || (a == csia_pkg::IND_PORT0_ADDR) || (a == csia_pkg::IND_PORT1_ADDR);
		ahb(1, csia_pkg::OFS_ARITH, s ? {24'h0, md, ~md, 4'h0} : {24'h0, ~md, md, 4'h0});
		ahb(1, s ? csia_pkg::OFS_PTR1 : csia_pkg::OFS_PTR0, {24'h0, a});
		bank_select <= 8'(rnd());
		x = 8'(rnd());
		@(posedge hclk);
		acc <= '{1'b1, s, w, x};
		#1;
		chk(mem.rd, !w && !n);
		chk(mem.wr, w && !n);
		if (!n) chk({mem.bank, mem.addr}, {bank_select, a});
		if (w && !n) chk(mem.wdata, x);
		p = u_mem.pat(bank_select, a);
		@(posedge hclk);
		acc <= '0;
		#1;
		if (!w) chk(ind_rdata, n ? 8'h00 : p);
		chk(result_null_set, !w && n);
		ahb(0, s ? csia_pkg::OFS_PTR1 : csia_pkg::OFS_PTR0, 0);
		chk(r, {24'h0, md[1] ? a : (md[0] ? a + 8'h01 : a - 8'h01)});
	endtask

	// ====================================================================
	// Clock and timeout
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ====================================================================
	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, push, pop} = 5'b0_1000;
		{haddr, hwdata, push_pc, bank_select} = '0;
		htrans = 2'b00;
		hsize = 3'b010;
		acc = '0;
		for (int i = 0; i < 16; i++) es[i] = 16'h0000;
		do_reset();
		chk(stack_room_flag, 1);
		for (int i = 0; i < 5; i++) begin
			ahb(0, 8'(i * 4), 0);
			chk(r, i == 3);
		end
		ahb(1, csia_pkg::OFS_CPUST, 0);
		ahb(0, csia_pkg::OFS_CPUST, 0);
		chk(r, 1);
		// Seventeen pushes: flag drops at fifteen, wraps, first entry overwritten
		for (int i = 0; i < 17; i++) begin
			stk(1, 0, 16'(rnd()));
			#1 chk(stack_room_flag, i < 14);
		end
		repeat (3) stk(0, 1, 0);
		#1 chk(stack_room_flag, 0);
		// Pop before push, then push locks the flag clear
		do_reset();
		for (int i = 0; i < 16; i++) es[i] = 16'h0000;
		stk(0, 1, 0);
		#1 chk(stack_room_flag, 0);
		stk(1, 0, 16'(rnd()));
		stk(0, 1, 0);
		stk(0, 1, 0);
		#1 chk(stack_room_flag, 0);
		// Push then pop on the very next cycle
		@(posedge hclk);
		push <= 1'b1;
		push_pc <= 16'h1234;
		@(posedge hclk);
		push <= 1'b0;
		pop <= 1'b1;
		es[sp] = 16'h1234;
		#1 chk(pop_pc, 16'h1234);
		@(posedge hclk);
		pop <= 1'b0;
		// Every mode on both pointers, reads and writes, random pointers
		for (int k = 0; k < 16; k++) ind(k[0], k[1], 8'(rnd()), k[3:2]);
		ind(0, 0, 8'hff, 2'b01);
		ind(1, 0, 8'h00, 2'b00);
		ind(0, 0, 8'h01, 2'b00);
		ind(1, 0, 8'h08, 2'b10);
		ind(0, 1, 8'h08, 2'b11);
		ind(1, 1, 8'h00, 2'b01);
		summarize();
	end
endmodule
